/* tmcnt_pkg.sv */
// Purpose: Constants and types for the 8-bit timer/counter block
// Assumes: AHB-Lite register bus, 32-bit data, word-aligned registers
// Notes: Offsets are byte addresses
package tmcnt_pkg;
	localparam logic [7:0] OFF_COUNT = 8'h00;
	localparam logic [7:0] OFF_OPTION = 8'h04;
	localparam logic [7:0] OFF_CAPCTL = 8'h08;
	localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
	localparam logic [7:0] OFF_INT_CLEAR = 8'h10;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h14;
	// Field positions in the option, CAPCTL and interrupt registers
	localparam int POS_CLK_SRC = 5;
	localparam int POS_EDGE_SEL = 4;
	localparam int POS_PSA = 3;
	localparam int POS_RATE = 0;
	localparam int POS_ALT_SRC = 0;
	localparam int POS_OVF = 0;
	// Values after reset
	localparam logic [5:0] RST_OPTION = 6'h3f;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_PRESC = 8'h00;
	// Instruction cycles of count suppression after a count write
	localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
	// Clock period and instruction cycle length (four phases)
	localparam int CLK_PERIOD_PS = 8000;
	localparam int INSTR_PERIOD_PS = 32000;
	localparam int CLKS_PER_INSTR = INSTR_PERIOD_PS / CLK_PERIOD_PS;

	typedef struct packed {
		logic clk_src;
		logic edge_sel;
		logic prescaler_assignment;
		logic [2:0] rate;
	} tmcnt_cfg_t;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} tmcnt_phase_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
	} tmcnt_bus_t;
endpackage

/* tmcnt_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to CLK
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
module tmcnt_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Filter rejects a single-sample glitch on the late stages
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dout <= 1'b0;
		end else if (s2_r == s3_r) begin
			dout <= s3_r;
		end
	end
endmodule

/* tmcnt_top.sv */
// Purpose: 8-bit timer/counter with prescaler shared with a watchdog
// Assumes: CLK at 125 MHz, four clocks form one instruction cycle
// Notes: Registers on AHB-Lite; reads take one wait state
`timescale 1ns/1ps

// Overview of operation
// - 8-bit count, timer mode ticks per instruction
// - Count write blocks counting two instruction cycles
// - Counter mode counts chosen edge of source
// - Source select one, alternate zero: count pin
// - Both selects one: count capacitive oscillator
// - Edge select applies to both sources
// - One prescaler, timer or watchdog, never both
// - Timer prescale ratios 1:2 to 1:256
// - Undivided timer only with prescaler on watchdog
// - Prescaler hidden; count write clears it when it is on the timer
// - Watchdog clear also clears assigned prescaler
// - Wrap ff to 00 sets overflow flag
// - Overflow flag cleared only by software
// - Interrupt when flag and enable both set
// - No counting, no overflow during sleep
// - Edge select one falling, zero rising
// - Rate codes double timer and watchdog ratios
// - Increments land on second and fourth phases
module tmcnt_top (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic COUNT_PIN,
	input wire logic CAP_OSC,
	input wire logic SLEEP,
	input wire logic WDT_CLEAR,
	input wire logic WDT_TICK,
	output logic WDT_SCALED,
	output logic IRQ
);
	import tmcnt_pkg::*;

	tmcnt_cfg_t cfg_r;
	tmcnt_phase_t phase_r;
	tmcnt_bus_t dph_r;
	logic [7:0] count_r;
	logic [7:0] presc_r;
	logic alt_src_r;
	logic ovf_r;
	logic ien_r;
	logic [1:0] inh_r;
	logic pend_r;
	logic pin_s;
	logic osc_s;
	logic src_lvl_r;
	logic [31:0] rdata_r;
	logic hready_r;
	logic irq_r;
	logic wdt_out_r;
	logic src_lvl;
	logic edge_ev;
	logic instr_tick;
	logic src_pulse;
	logic presc_hit;
	logic raw_pulse;
	logic inc;
	logic cnt_wr;
	logic opt_wr;
	logic clr_wr;
	logic ap;

	// Low-bit mask for a division of two to the given power
	function automatic logic [7:0] div_mask(input logic [2:0] rate,
		input logic extra);
		logic [8:0] m;
		m = (9'h001 << ({1'b0, rate} + {3'h0, extra})) - 9'h001;
		return m[7:0];
	endfunction

	function automatic logic is_wr(input tmcnt_bus_t b,
		input logic [7:0] off);
		return b.wr && (b.addr == off);
	endfunction

	tmcnt_sync u_pin_sync (
		.clk(CLK),
		.reset_n(RESET_N),
		.din(COUNT_PIN),
		.dout(pin_s)
	);

	tmcnt_sync u_osc_sync (
		.clk(CLK),
		.reset_n(RESET_N),
		.din(CAP_OSC),
		.dout(osc_s)
	);

	// Bus decode
	assign ap = HSEL && HTRANS[1] && HREADY;
	assign cnt_wr = is_wr(dph_r, OFF_COUNT);
	assign opt_wr = is_wr(dph_r, OFF_OPTION);
	assign clr_wr = is_wr(dph_r, OFF_INT_CLEAR) && HWDATA[POS_OVF];

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			dph_r <= '0;
		end else begin
			dph_r.wr <= ap && HWRITE;
			dph_r.rd <= ap && !HWRITE;
			dph_r.addr <= ap ? HADDR[7:0] : dph_r.addr;
		end
	end

	// Reads wait one cycle so HRDATA can come from a flop and see
	// a write that completes in the same cycle as the read request
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			hready_r <= 1'b1;
			rdata_r <= '0;
		end else if (ap && !HWRITE) begin
			hready_r <= 1'b0;
		end else if (dph_r.rd) begin
			hready_r <= 1'b1;
			case (dph_r.addr)
				OFF_COUNT: rdata_r <= {24'h0, count_r};
				OFF_OPTION: rdata_r <= {26'h0, cfg_r};
				OFF_CAPCTL: rdata_r <= {31'h0, alt_src_r};
				OFF_INT_STATUS: rdata_r <= {31'h0, ovf_r};
				OFF_INT_ENABLE: rdata_r <= {31'h0, ien_r};
				default: rdata_r <= '0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			cfg_r <= RST_OPTION;
			alt_src_r <= 1'b0;
			ien_r <= 1'b0;
		end else begin
			if (opt_wr) begin
				cfg_r <= HWDATA[5:0];
			end
			if (is_wr(dph_r, OFF_CAPCTL)) begin
				alt_src_r <= HWDATA[POS_ALT_SRC];
			end
			if (is_wr(dph_r, OFF_INT_ENABLE)) begin
				ien_r <= HWDATA[POS_OVF];
			end
		end
	end

	// Instruction cycle phases
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			phase_r <= PH_Q1;
		end else begin
			case (phase_r)
				PH_Q1: phase_r <= PH_Q2;
				PH_Q2: phase_r <= PH_Q3;
				PH_Q3: phase_r <= PH_Q4;
				PH_Q4: phase_r <= PH_Q1;
				default: phase_r <= PH_Q1;
			endcase
		end
	end
	assign instr_tick = (phase_r == PH_Q4);

	// Counter input source and edge
	assign src_lvl = alt_src_r ? osc_s : pin_s;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			src_lvl_r <= 1'b0;
		end else begin
			src_lvl_r <= src_lvl;
		end
	end

	// Same polarity for either source
	assign edge_ev = cfg_r.edge_sel ? (src_lvl_r && !src_lvl)
		: (!src_lvl_r && src_lvl);

	// Sleep freezes the timer path only; the watchdog keeps its tick
	assign src_pulse = !SLEEP && (cfg_r.clk_src ? edge_ev
		: instr_tick);

	// Prescaler is owned by exactly one side at any time
	assign presc_hit = cfg_r.prescaler_assignment
		? (WDT_TICK && ((presc_r & div_mask(cfg_r.rate, 1'b0))
		== div_mask(cfg_r.rate, 1'b0)))
		: (src_pulse && ((presc_r & div_mask(cfg_r.rate, 1'b1))
		== div_mask(cfg_r.rate, 1'b1)));

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			presc_r <= RST_PRESC;
		end else if (cnt_wr && !cfg_r.prescaler_assignment) begin
			presc_r <= RST_PRESC;
		end else if (WDT_CLEAR && cfg_r.prescaler_assignment) begin
			presc_r <= RST_PRESC;
		end else if (cfg_r.prescaler_assignment ? WDT_TICK : src_pulse) begin
			presc_r <= presc_r + 8'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wdt_out_r <= 1'b0;
		end else begin
			wdt_out_r <= cfg_r.prescaler_assignment && presc_hit && !WDT_CLEAR;
		end
	end

	// Undivided source when the prescaler sits on the watchdog
	assign raw_pulse = cfg_r.prescaler_assignment ? src_pulse
		: presc_hit;

	// Pending increment waits for the next sampling phase
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			pend_r <= 1'b0;
		end else if (cnt_wr || inh_r != 2'h0 || SLEEP) begin
			pend_r <= 1'b0;
		end else if (raw_pulse) begin
			pend_r <= 1'b1;
		end else if (inc) begin
			pend_r <= 1'b0;
		end
	end

	assign inc = pend_r && !SLEEP && inh_r == 2'h0 && !cnt_wr
		&& (phase_r == PH_Q2 || phase_r == PH_Q4);

	// Inhibit counts instruction ticks (PH_Q4) after the write
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			inh_r <= 2'h0;
		end else if (cnt_wr) begin
			inh_r <= INHIBIT_CYCLES;
		end else if (instr_tick && inh_r != 2'h0) begin
			inh_r <= inh_r - 2'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			count_r <= RST_COUNT;
		end else if (cnt_wr) begin
			count_r <= HWDATA[7:0];
		end else if (inc) begin
			count_r <= count_r + 8'h01;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ovf_r <= 1'b0;
		end else if (inc && count_r == 8'hff) begin
			ovf_r <= 1'b1;
		end else if (clr_wr) begin
			ovf_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= ovf_r && ien_r;
		end
	end

	assign HRDATA = rdata_r;
	assign HREADYOUT = hready_r;
	assign HRESP = 1'b0;
	assign WDT_SCALED = wdt_out_r;
	assign IRQ = irq_r;

	AST_INHIBIT: assert property (@(posedge CLK) disable iff (!RESET_N)
		cnt_wr |=> !inc [*6])
		else $error("count advanced inside write inhibit");
	AST_OVF_SET: assert property (@(posedge CLK) disable iff (!RESET_N)
		inc && count_r == 8'hff |=> ovf_r && count_r == 8'h00)
		else $error("wrap did not set overflow flag");
	AST_OVF_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
		ovf_r && !clr_wr |=> ovf_r)
		else $error("overflow flag dropped without clear");
	AST_IRQ: assert property (@(posedge CLK) disable iff (!RESET_N)
		IRQ == ($past(ovf_r) && $past(ien_r)))
		else $error("interrupt output mismatch");
	AST_SLEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
		SLEEP |=> $stable(count_r) || $past(cnt_wr))
		else $error("count moved during sleep");
	AST_PRESC_WR: assert property (@(posedge CLK) disable iff (!RESET_N)
		cnt_wr && !cfg_r.prescaler_assignment |=> presc_r == 8'h00)
		else $error("count write left prescaler");
	AST_PRESC_WDT: assert property (@(posedge CLK) disable iff (!RESET_N)
		WDT_CLEAR && cfg_r.prescaler_assignment |=> presc_r == 8'h00)
		else $error("watchdog clear left prescaler");
	AST_PHASE: assert property (@(posedge CLK) disable iff (!RESET_N)
		inc |-> phase_r == PH_Q2 || phase_r == PH_Q4)
		else $error("increment outside sampling phase");
	AST_STEP: assert property (@(posedge CLK) disable iff (!RESET_N)
		inc |=> count_r == $past(count_r) + 8'h01)
		else $error("count did not step by one");
	AST_TIMER_1TO1: assert property (@(posedge CLK) disable iff (!RESET_N)
		cfg_r.prescaler_assignment && !cfg_r.clk_src && !SLEEP && instr_tick && inh_r == 2'h0
		&& !cnt_wr && !$past(opt_wr)
		|=> ##1 inc || cnt_wr || SLEEP || opt_wr || $past(cnt_wr)
		|| $past(SLEEP))
		else $error("undivided timer missed a cycle");

	COV_OVF: cover property (@(posedge CLK) disable iff (!RESET_N)
		inc && count_r == 8'hff);
	COV_PIN: cover property (@(posedge CLK) disable iff (!RESET_N)
		cfg_r.clk_src && !alt_src_r && inc);
	COV_OSC: cover property (@(posedge CLK) disable iff (!RESET_N)
		cfg_r.clk_src && alt_src_r && inc);
	COV_IRQ: cover property (@(posedge CLK) disable iff (!RESET_N)
		$rose(IRQ));
endmodule

/* tmcnt_src_model.sv */
// Purpose: Pulse source for the count pin and the cap sense oscillator
// Assumes: One request at a time, taken only while idle
// Notes: Both lines rest low between pulses
`timescale 1ns/1ps
module tmcnt_src_model #(
	parameter int HIGH_CLKS = 40
) (
	input wire logic clk,
	input wire logic go_pin,
	input wire logic go_osc,
	output logic pin,
	output logic osc,
	output logic busy
);
	int cnt = 0;
	logic sel = 1'b0;
	// Long high and low times keep each edge clear of the synchroniser
	always_ff @(posedge clk) begin
		if (cnt != 0) begin
			cnt <= cnt - 1;
		end else if (go_pin || go_osc) begin
			cnt <= 2 * HIGH_CLKS;
			sel <= go_osc;
		end
	end
	assign busy = (cnt != 0);
	assign pin = !sel && (cnt > HIGH_CLKS);
	assign osc = sel && (cnt > HIGH_CLKS);
endmodule

/* test_eight_bit_timer_counter_shared_prescaler.sv */
// Purpose: Register-level tests of the timer/counter
// Assumes: AHB-Lite single word transfers, HREADY fed back
// Notes: Timing checks use small windows for bus latency
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_eight_bit_timer_counter_shared_prescaler;
	import tmcnt_pkg::*;
	logic clk = 0, reset_n = 0, sleep = 0, wdt_clear = 0, wdt_tick = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic hreadyout, hresp, wdt_scaled, irq, pin, osc, busy;
	logic go_pin = 0, go_osc = 0;
	int bad_count = 0, checks = 0, nsc = 0;
	initial begin
		forever #4 clk = ~clk;
	end
	tmcnt_top i_dut (.CLK(clk), .RESET_N(reset_n), .HSEL(1'b1),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .COUNT_PIN(pin),
		.CAP_OSC(osc), .SLEEP(sleep), .WDT_CLEAR(wdt_clear),
		.WDT_TICK(wdt_tick), .WDT_SCALED(wdt_scaled), .IRQ(irq));
	tmcnt_src_model i_src (.clk(clk), .go_pin(go_pin), .go_osc(go_osc),
		.pin(pin), .osc(osc), .busy(busy));
	always @(posedge clk) begin
		if (wdt_scaled === 1'b1)
			nsc++;
	end
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk);
		while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk);
		while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start(input logic o);
		// Let any count-write inhibit run out before the edge arrives
		wt(12);
		@(posedge clk);
		go_pin <= !o;
		go_osc <= o;
		@(posedge clk);
		go_pin <= 1'b0;
		go_osc <= 1'b0;
	endtask
	task automatic pulse(input logic o, input int n);
		repeat (n) begin
			start(o);
			do @(posedge clk);
			while (busy);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			wdt_tick <= 1'b1;
			@(posedge clk);
			wdt_tick <= 1'b0;
		end
		wt(3);
	endtask
	task automatic clr_wdt();
		@(posedge clk);
		wdt_clear <= 1'b1;
		@(posedge clk);
		wdt_clear <= 1'b0;
	endtask
	task print_verdict();
		$display("Counts: checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Tests need about 20000 clocks; three times that means a hang
	initial begin
		wt(60000);
		bad_count++;
		print_verdict();
	end
	initial begin
		wt(4);
		reset_n <= 1'b1;
		rd(OFF_OPTION);
		`CHK(q, 32'h3f)
		rd(OFF_COUNT);
		`CHK(q, 32'h0)
		rd(8'h20);
		`CHK(q, 32'h0)
		`CHK(hresp, 1'b0)
		$display("Test reset done");
		wr(OFF_OPTION, 32'h08);
		wr(OFF_COUNT, 32'h40);
		rd(OFF_COUNT);
		`CHK(q, 32'h40)
		wt(400);
		rd(OFF_COUNT);
		`CHK(q >= 161 && q <= 166, 1'b1)
		for (int r = 0; r < 8; r++) begin
			wr(OFF_OPTION, 32'(r));
			wr(OFF_COUNT, 32'h0);
			wt(64 << r);
			rd(OFF_COUNT);
			`CHK(q >= 6 && q <= 9, 1'b1)
		end
		$display("Test timer rates done");
		wr(OFF_OPTION, 32'h08);
		wr(OFF_COUNT, 32'hfd);
		wt(40);
		rd(OFF_INT_STATUS);
		`CHK(q, 32'h1)
		`CHK(irq, 1'b0)
		wt(1100);
		rd(OFF_INT_STATUS);
		`CHK(q, 32'h1)
		sleep <= 1'b1;
		wr(OFF_INT_ENABLE, 32'h1);
		wt(2);
		`CHK(irq, 1'b1)
		wr(OFF_INT_CLEAR, 32'h1);
		wt(2);
		`CHK(irq, 1'b0)
		rd(OFF_INT_CLEAR);
		`CHK(q, 32'h0)
		wr(OFF_COUNT, 32'hff);
		wt(200);
		rd(OFF_COUNT);
		`CHK(q, 32'hff)
		rd(OFF_INT_STATUS);
		`CHK(q, 32'h0)
		sleep <= 1'b0;
		wt(40);
		rd(OFF_INT_STATUS);
		`CHK(q, 32'h1)
		wr(OFF_INT_CLEAR, 32'h1);
		wr(OFF_INT_ENABLE, 32'h0);
		$display("Test overflow done");
		wr(OFF_OPTION, 32'h28);
		wr(OFF_CAPCTL, 32'h0);
		wr(OFF_COUNT, 32'h0);
		pulse(1'b0, 3);
		pulse(1'b1, 2);
		rd(OFF_COUNT);
		`CHK(q, 32'h3)
		wr(OFF_CAPCTL, 32'h1);
		rd(OFF_CAPCTL);
		`CHK(q, 32'h1)
		wr(OFF_COUNT, 32'h0);
		pulse(1'b1, 2);
		pulse(1'b0, 1);
		rd(OFF_COUNT);
		`CHK(q, 32'h2)
		wr(OFF_OPTION, 32'h20);
		wr(OFF_COUNT, 32'h0);
		pulse(1'b1, 4);
		rd(OFF_COUNT);
		`CHK(q, 32'h2)
		for (int e = 0; e < 2; e++) begin
			wr(OFF_OPTION, 32'h28 | (32'(e) << 4));
			wr(OFF_COUNT, 32'h0);
			start(1'b1);
			wt(20);
			rd(OFF_COUNT);
			`CHK(q, 32'(e == 0))
			pulse(1'b0, 0);
			wt(90);
			rd(OFF_COUNT);
			`CHK(q, 32'h1)
		end
		$display("Test counter done");
		wr(OFF_OPTION, 32'h08);
		nsc = 0;
		tick(5);
		`CHK(nsc, 5)
		wr(OFF_OPTION, 32'h0a);
		clr_wdt();
		nsc = 0;
		tick(2);
		clr_wdt();
		tick(3);
		`CHK(nsc, 0)
		tick(1);
		`CHK(nsc, 1)
		wr(OFF_OPTION, 32'h02);
		nsc = 0;
		tick(4);
		`CHK(nsc, 0)
		$display("Test watchdog done");
		print_verdict();
	end
endmodule
